// *** src/ltf_top.v ***
// logic trigger qualification and front-panel channel control
//
// How it works
// - with qualify on, trigger only at chosen ext clock edge if function true; a nested gate then holds every clock while B true
// - slope set selects rising ext clock edge, cleared selects falling
// - replica trace shows ext clock while qualify is on
// - reset pin forces trigger function false, no trigger output
// - reset in nested mode clears armed state and blocks function B
// - trigger from source select, both programs and live channel levels
// - normal variant gives one pulse per nested fire; gate variant selectable
// - mode key toggles setup and program modes; keys gated by mode
// - setup-mode channel key selects target channel, shown on indicator
// - display off hides trace only; grounded channel leaves trigger logic
// - three sensitivities per family, up key more sensitive, scale to readout
// - ground state disconnects input and grounds the amplifier
// - preset threshold per family: +1.4 V or -1.30 V
// - readout shows selected threshold; second press blanks it only
// - each level press steps one increment; holding repeats faster
// - family change drops adjusted threshold, loads new preset unless the channel has a captured offset
// - offset key: red voltmeter, green capture, off clears to preset
// - offset sequence only with readout on and a channel selected
// - captured offset persists; family change reverts threshold to offset
// - in setup mode, selected channel with non-zero offset lights offset indicator green
// - level keys act only in setup mode with readout on
// - held stepping pauses at preset unless channel has captured offset
// - nested: arm on A, fire on next B, then wait for A again
`default_nettype none
`include "ltf_regs.vh"

module ltf_top #(
	parameter [`LTF_CNT_W-1:0] REP_SLOW_CYC = `LTF_REP_SLOW_US * `LTF_CLK_MHZ,
	parameter [`LTF_CNT_W-1:0] REP_FAST_CYC = `LTF_REP_FAST_US * `LTF_CLK_MHZ,
	parameter [`LTF_CNT_W-1:0] PAUSE_CYC    = `LTF_PAUSE_US * `LTF_CLK_MHZ
) (
	// clock and reset
	input  wire        REF_CLK_I,
	input  wire        RESET_I,
	// circuit under test pins
	input  wire        EXT_CLK_I,
	input  wire        TRIG_RESET_I,
	input  wire [3:0]  CHAN_LEVEL_I,
	// trigger configuration
	input  wire        QUALIFY_EN_I,
	input  wire        SLOPE_RISE_I,
	input  wire        REPLICA_SEL_I,
	input  wire        GATE_VARIANT_I,
	input  wire [1:0]  FUNC_SEL_I,
	input  wire [7:0]  FUNC_A_CARE_I,
	input  wire [7:0]  FUNC_A_POL_I,
	input  wire [7:0]  FUNC_B_CARE_I,
	input  wire [7:0]  FUNC_B_POL_I,
	// front-panel key pulses
	input  wire        KEY_MODE_I,
	input  wire [3:0]  KEY_CHAN_I,
	input  wire        KEY_DISPLAY_I,
	input  wire        KEY_GND_I,
	input  wire        KEY_IMP_I,
	input  wire        KEY_FAMILY_I,
	input  wire        KEY_SENS_UP_I,
	input  wire        KEY_SENS_DN_I,
	input  wire        KEY_READOUT_I,
	input  wire        KEY_OFFSET_I,
	input  wire [4:0]  KEY_PROG_I,
	// level keys, high while held
	input  wire        KEY_LVL_UP_I,
	input  wire        KEY_LVL_DN_I,
	// probe voltmeter sample, 10 mV units
	input  wire [9:0]  PROBE_VOLT_I,
	// trigger outputs
	output reg         TRIG_O,
	output reg         REPLICA_O,
	// channel status
	output reg         SETUP_MODE_O,
	output reg  [3:0]  CHAN_SEL_O,
	output reg  [3:0]  DISPLAY_EN_O,
	output reg  [3:0]  GND_O,
	output reg  [3:0]  IMP_HIGH_O,
	output reg  [3:0]  FAMILY_TTL_O,
	output reg  [7:0]  SENS_O,
	output reg  [9:0]  SCALE_MV_O,
	output wire [39:0] THRESHOLD_READOUT_O,
	// readout and indicators
	output reg         READOUT_ON_O,
	output reg  [9:0]  READOUT_O,
	output reg         OFFSET_RED_O,
	output reg         OFFSET_GREEN_O,
	output reg  [8:0]  PROG_KEY_O
);

	// ********************
	// functions
	// ********************
	function [1:0] idx;
		input [3:0] oh;
		begin
			idx = oh[3] ? 2'h3 : oh[2] ? 2'h2 : oh[1] ? 2'h1 : 2'h0;
		end
	endfunction

	// two product columns ORed; an all-don't-care column is inactive
	function eval;
		input [7:0] care;
		input [7:0] pol;
		input [3:0] lv;
		begin
			eval = ((|care[3:0]) && ((care[3:0] & (pol[3:0] ^ lv)) == 4'h0))
			    || ((|care[7:4]) && ((care[7:4] & (pol[7:4] ^ lv)) == 4'h0));
		end
	endfunction

	function [9:0] preset;
		input ttl;
		begin
			preset = ttl ? `LTF_TTL_PRESET : `LTF_ECL_PRESET;
		end
	endfunction

	function [9:0] scale;
		input       ttl;
		input [1:0] s;
		begin
			case (s)
				2'h0:    scale = ttl ? `LTF_TTL_SC0 : `LTF_ECL_SC0;
				2'h1:    scale = ttl ? `LTF_TTL_SC1 : `LTF_ECL_SC1;
				default: scale = ttl ? `LTF_TTL_SC2 : `LTF_ECL_SC2;
			endcase
		end
	endfunction

	// ********************
	// input synchronisation
	// ********************
	wire [5:0] pin_s;
	reg        ext_prev_q;

	ltf_sync #(.W(6)) u_sync (
		.clk_i (REF_CLK_I),
		.rst_i (RESET_I),
		.d_i   ({TRIG_RESET_I, EXT_CLK_I, CHAN_LEVEL_I}),
		.q_o   (pin_s)
	);

	wire       ext_s  = pin_s[4];
	wire       trst_s = pin_s[5];
	wire [3:0] lvl_s  = pin_s[3:0] & ~GND_O;
	wire       ext_edge = SLOPE_RISE_I ? (ext_s & ~ext_prev_q)
	                                   : (~ext_s & ext_prev_q);

	// ********************
	// trigger evaluation
	// ********************
	localparam [2:0] NS_WAIT_A = 3'h1;
	localparam [2:0] NS_ARMED  = 3'h2;
	localparam [2:0] NS_GATE   = 3'h4;

	reg  [2:0] ns_q;
	reg  [2:0] ns_d;
	reg        fa_prev_q;
	reg        fb_prev_q;
	reg        trig_d;

	// reset pin masks the functions
	wire fa = eval(FUNC_A_CARE_I, FUNC_A_POL_I, lvl_s) & ~trst_s;
	wire fb = eval(FUNC_B_CARE_I, FUNC_B_POL_I, lvl_s) & ~trst_s;
	// an occurrence is a clock-qualified sample or a new rise of the function
	wire occ_a = QUALIFY_EN_I ? (ext_edge & fa) : (fa & ~fa_prev_q);
	wire occ_b = QUALIFY_EN_I ? (ext_edge & fb) : (fb & ~fb_prev_q);
	wire fsel  = (FUNC_SEL_I == `LTF_SEL_B) ? fb : fa;

	always @* begin
		ns_d   = ns_q;
		trig_d = 1'b0;
		if (FUNC_SEL_I != `LTF_SEL_NEST) begin
			ns_d   = NS_WAIT_A;
			trig_d = QUALIFY_EN_I ? (ext_edge & fsel) : fsel;
		end else if (trst_s) begin
			ns_d = NS_WAIT_A;
		end else begin
			case (ns_q)
				NS_WAIT_A: begin
					if (occ_a)
						ns_d = NS_ARMED;
				end
				NS_ARMED: begin
					if (occ_b) begin
						trig_d = 1'b1;
						ns_d   = GATE_VARIANT_I ? NS_GATE : NS_WAIT_A;
					end
				end
				NS_GATE: begin
					// gate holds until b is false, checked every clock even when qualified
					if (fb) begin
						trig_d = 1'b1;
					end else begin
						ns_d = NS_WAIT_A;
					end
				end
				default: ns_d = NS_WAIT_A;
			endcase
		end
	end

	always @(posedge REF_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ns_q       <= NS_WAIT_A;
			ext_prev_q <= 1'b0;
			fa_prev_q  <= 1'b0;
			fb_prev_q  <= 1'b0;
			TRIG_O     <= 1'b0;
			REPLICA_O  <= 1'b0;
		end else begin
			ns_q       <= ns_d;
			ext_prev_q <= ext_s;
			fa_prev_q  <= fa;
			fb_prev_q  <= fb;
			TRIG_O     <= trig_d;
			REPLICA_O  <= REPLICA_SEL_I & (QUALIFY_EN_I ? ext_s : trig_d);
		end
	end

	// ********************
	// channel setup
	// ********************
	wire [1:0] sel      = idx(CHAN_SEL_O);
	wire       in_setup = SETUP_MODE_O;

	reg signed [9:0] th_q  [0:3];
	reg        [9:0] ofs_q [0:3];
	reg        [3:0] ofs_valid_q;
	integer          i;

	assign THRESHOLD_READOUT_O = {th_q[3], th_q[2], th_q[1], th_q[0]};

	// ********************
	// level key repeat
	// ********************
	reg  [`LTF_CNT_W-1:0] rep_cnt_q;
	reg  [`LTF_CNT_W-1:0] rep_int_q;
	reg                   held_prev_q;
	wire lvl_en = in_setup & READOUT_ON_O;
	wire held   = lvl_en & (KEY_LVL_UP_I ^ KEY_LVL_DN_I);
	wire press  = held & ~held_prev_q;
	wire repeat_hit = held & held_prev_q & (rep_cnt_q == {`LTF_CNT_W{1'b0}});
	wire step   = press | repeat_hit;
	wire [`LTF_CNT_W-1:0] half_int = {1'b0, rep_int_q[`LTF_CNT_W-1:1]};
	wire [`LTF_CNT_W-1:0] next_int = (half_int < REP_FAST_CYC) ?
	                                 REP_FAST_CYC : half_int;

	wire signed [9:0] th_sel = th_q[sel];
	wire [9:0] th_step = KEY_LVL_UP_I ?
		((th_sel == $signed(`LTF_TH_MAX)) ? th_sel : th_sel + 10'h001) :
		((th_sel == $signed(`LTF_TH_MIN)) ? th_sel : th_sel - 10'h001);
	wire at_preset = (th_step == preset(FAMILY_TTL_O[sel]));
	wire do_pause  = at_preset & ~ofs_valid_q[sel];

	always @(posedge REF_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			rep_cnt_q   <= {`LTF_CNT_W{1'b0}};
			rep_int_q   <= {`LTF_CNT_W{1'b0}};
			held_prev_q <= 1'b0;
		end else begin
			held_prev_q <= held;
			if (press) begin
				rep_int_q <= REP_SLOW_CYC;
				rep_cnt_q <= do_pause ? PAUSE_CYC : REP_SLOW_CYC;
			end else if (repeat_hit) begin
				// interval halves each repeat down to the fast floor
				rep_int_q <= next_int;
				rep_cnt_q <= do_pause ? PAUSE_CYC : next_int;
			end else if (held && rep_cnt_q != {`LTF_CNT_W{1'b0}}) begin
				rep_cnt_q <= rep_cnt_q - {{(`LTF_CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ********************
	// probe offset sequence
	// ********************
	localparam [2:0] OF_IDLE = 3'h1;
	localparam [2:0] OF_MEAS = 3'h2;
	localparam [2:0] OF_HELD = 3'h4;

	reg  [2:0] of_q;
	reg  [2:0] of_d;
	reg        of_capture;
	reg        of_clear;
	wire       of_key   = KEY_OFFSET_I & lvl_en & (|CHAN_SEL_O);
	wire       chan_key = in_setup & (|KEY_CHAN_I);
	wire       ofs_nz   = (ofs_q[sel] != 10'h000);

	always @* begin
		of_d       = of_q;
		of_capture = 1'b0;
		of_clear   = 1'b0;
		case (of_q)
			OF_IDLE: begin
				if (of_key && ofs_valid_q[sel]) begin
					of_clear = 1'b1;
				end else if (of_key) begin
					of_d = OF_MEAS;
				end
			end
			OF_MEAS: begin
				if (of_key) begin
					of_capture = 1'b1;
					of_d       = OF_HELD;
				end else if (chan_key || !lvl_en) begin
					// leaving the voltmeter view abandons the measurement
					of_d = OF_IDLE;
				end
			end
			OF_HELD: begin
				if (of_key) begin
					of_clear = 1'b1;
					of_d     = OF_IDLE;
				end else if (chan_key || !lvl_en) begin
					of_d = OF_IDLE;
				end
			end
			default: of_d = OF_IDLE;
		endcase
	end

	// ********************
	// front-panel state
	// ********************
	always @(posedge REF_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			of_q           <= OF_IDLE;
			SETUP_MODE_O   <= 1'b1;
			CHAN_SEL_O     <= 4'h1;
			DISPLAY_EN_O   <= 4'hf;
			GND_O          <= 4'h0;
			IMP_HIGH_O     <= 4'hf;
			FAMILY_TTL_O   <= 4'hf;
			SENS_O         <= {4{`LTF_SENS_RST}};
			SCALE_MV_O     <= `LTF_TTL_SC0;
			READOUT_ON_O   <= 1'b0;
			READOUT_O      <= 10'h000;
			OFFSET_RED_O   <= 1'b0;
			OFFSET_GREEN_O <= 1'b0;
			PROG_KEY_O     <= 9'h000;
			ofs_valid_q    <= 4'h0;
			for (i = 0; i < 4; i = i + 1) begin
				th_q[i]  <= `LTF_TTL_PRESET;
				ofs_q[i] <= 10'h000;
			end
		end else begin
			of_q <= of_d;
			if (KEY_MODE_I)
				SETUP_MODE_O <= ~SETUP_MODE_O;
			// program keys pass on only in program mode
			PROG_KEY_O <= in_setup ? 9'h000 : {KEY_CHAN_I, KEY_PROG_I};
			if (chan_key)
				CHAN_SEL_O <= KEY_CHAN_I[0] ? 4'h1 : KEY_CHAN_I[1] ? 4'h2 :
				              KEY_CHAN_I[2] ? 4'h4 : 4'h8;
			if (in_setup) begin
				if (KEY_DISPLAY_I)
					DISPLAY_EN_O[sel] <= ~DISPLAY_EN_O[sel];
				if (KEY_GND_I)
					GND_O[sel] <= ~GND_O[sel];
				if (KEY_IMP_I)
					IMP_HIGH_O[sel] <= ~IMP_HIGH_O[sel];
				if (KEY_READOUT_I)
					READOUT_ON_O <= ~READOUT_ON_O;
				if (KEY_SENS_UP_I && SENS_O[2*sel +: 2] != `LTF_SENS_MAX)
					SENS_O[2*sel +: 2] <= SENS_O[2*sel +: 2] + 2'h1;
				else if (KEY_SENS_DN_I && SENS_O[2*sel +: 2] != 2'h0)
					SENS_O[2*sel +: 2] <= SENS_O[2*sel +: 2] - 2'h1;
				if (KEY_FAMILY_I) begin
					FAMILY_TTL_O[sel] <= ~FAMILY_TTL_O[sel];
					// adjusted value is lost; a captured offset survives
					th_q[sel] <= ofs_valid_q[sel] ? ofs_q[sel]
					           : preset(~FAMILY_TTL_O[sel]);
				end else if (step) begin
					th_q[sel] <= th_step;
				end
			end
			if (of_capture) begin
				ofs_q[sel]       <= PROBE_VOLT_I;
				ofs_valid_q[sel] <= 1'b1;
				th_q[sel]        <= PROBE_VOLT_I;
			end else if (of_clear) begin
				ofs_q[sel]       <= 10'h000;
				ofs_valid_q[sel] <= 1'b0;
				th_q[sel]        <= preset(FAMILY_TTL_O[sel]);
			end
			SCALE_MV_O <= scale(FAMILY_TTL_O[sel], SENS_O[2*sel +: 2]);
			// blanked readout leaves every threshold untouched
			READOUT_O <= !READOUT_ON_O ? 10'h000 :
			             (of_q == OF_MEAS) ? PROBE_VOLT_I : th_sel;
			OFFSET_RED_O   <= (of_q == OF_MEAS);
			OFFSET_GREEN_O <= (of_q == OF_HELD) | (in_setup & ofs_nz);
		end
	end

endmodule
`default_nettype wire

// *** src/ltf_regs.vh ***
// constants for the logic trigger and front-panel control block
`ifndef LTF_REGS_VH
`define LTF_REGS_VH

// ********************
// clock and key repeat timing
// ********************
`define LTF_CLK_MHZ      25
`define LTF_REP_SLOW_US  400000
`define LTF_REP_FAST_US  25000
`define LTF_PAUSE_US     600000
`define LTF_CNT_W        24

// ********************
// trigger source select codes
// ********************
`define LTF_SEL_A        2'h0
`define LTF_SEL_B        2'h1
`define LTF_SEL_NEST     2'h2

// ********************
// thresholds, signed, units of 10 mV
// ********************
`define LTF_TH_W         10
`define LTF_TTL_PRESET   10'h08c
`define LTF_ECL_PRESET   10'h37e
`define LTF_TH_MAX       10'h1f4
`define LTF_TH_MIN       10'h20c

// ********************
// scale factors in mV/div, index 2 is most sensitive
// ********************
`define LTF_TTL_SC0      10'h1f4
`define LTF_TTL_SC1      10'h0c8
`define LTF_TTL_SC2      10'h064
`define LTF_ECL_SC0      10'h064
`define LTF_ECL_SC1      10'h032
`define LTF_ECL_SC2      10'h014
`define LTF_SENS_MAX     2'h2
`define LTF_SENS_RST     2'h0

`endif

// *** src/ltf_sync.v ***
// two-stage synchroniser for inputs from outside the clock domain
`default_nettype none

module ltf_sync #(
	parameter W = 1
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);

	reg [W-1:0] meta_q;

	// first stage feeds only the second stage
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= {W{1'b0}};
			q_o    <= {W{1'b0}};
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule
`default_nettype wire

// *** test/ltf_cut.sv ***
// model of the circuit under test and its external clock
`default_nettype none

module ltf_cut (
	input  wire logic       run_i,
	input  wire logic [3:0] lvl_i,
	output var  logic       ext_clk_o,
	output wire logic [3:0] lvl_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// ********************
	// clock and data source
	// ********************
	logic [3:0] count_q;

	// data moves mid-high so either clock edge sees settled levels
	assign lvl_o = run_i ? count_q : lvl_i;

	// clock stands still low outside a burst
	initial begin
		ext_clk_o = 1'b0;
		count_q = 4'h0;
		forever begin
			if (run_i) begin
				#160 ext_clk_o = 1'b1;
				#80 count_q = count_q + 4'h1;
				#80 ext_clk_o = 1'b0;
			end else begin
				count_q = 4'h0;
				#13;
			end
		end
	end
endmodule

`default_nettype wire

// *** test/ltf_props.sv ***
// concurrent checks on the trigger and front-panel ports
`default_nettype none

module ltf_props (
	input wire logic        REF_CLK_I,
	input wire logic        RESET_I,
	input wire logic        EXT_CLK_I,
	input wire logic        TRIG_RESET_I,
	input wire logic        QUALIFY_EN_I,
	input wire logic        SLOPE_RISE_I,
	input wire logic        REPLICA_SEL_I,
	input wire logic        GATE_VARIANT_I,
	input wire logic        KEY_MODE_I,
	input wire logic [3:0]  KEY_CHAN_I,
	input wire logic        KEY_DISPLAY_I,
	input wire logic        KEY_GND_I,
	input wire logic        KEY_FAMILY_I,
	input wire logic        TRIG_O,
	input wire logic        REPLICA_O,
	input wire logic        SETUP_MODE_O,
	input wire logic [3:0]  CHAN_SEL_O,
	input wire logic [3:0]  DISPLAY_EN_O,
	input wire logic [3:0]  GND_O,
	input wire logic [39:0] THRESHOLD_READOUT_O,
	input wire logic        READOUT_ON_O
);
	timeunit 1ns;
	timeprecision 100ps;

	// ********************
	// assertions
	// ********************
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RESET_I);

	chk_reset_inhibit: assert property (
		TRIG_RESET_I [*4] |-> !TRIG_O)
		else $error("trigger while reset pin high");
	chk_qual_pulse: assert property (
		QUALIFY_EN_I && $past(QUALIFY_EN_I) && !GATE_VARIANT_I && TRIG_O
		|=> !TRIG_O)
		else $error("qualified trigger longer than one cycle");
	// window of 3 to 6 samples tolerates the synchroniser depth
	chk_qual_edge: assert property (
		$rose(TRIG_O) && QUALIFY_EN_I && $past(QUALIFY_EN_I, 6)
		|-> $past(EXT_CLK_I, 3) == SLOPE_RISE_I
		&& $past(EXT_CLK_I, 6) != SLOPE_RISE_I)
		else $error("qualified trigger not at chosen edge");
	chk_replica_clk: assert property (
		REPLICA_SEL_I && QUALIFY_EN_I && $past(REPLICA_SEL_I, 4)
		&& $past(QUALIFY_EN_I, 4) && $past(EXT_CLK_I, 2) == $past(EXT_CLK_I, 4)
		|-> REPLICA_O == $past(EXT_CLK_I, 3))
		else $error("replica does not follow external clock");
	chk_chan_select: assert property (
		SETUP_MODE_O && !KEY_MODE_I && KEY_CHAN_I != 4'h0
		|=> CHAN_SEL_O == ($past(KEY_CHAN_I) & (~$past(KEY_CHAN_I) + 4'h1)))
		else $error("channel key did not select");
	chk_threshold_readout_hold: assert property (
		!SETUP_MODE_O || !READOUT_ON_O && !KEY_FAMILY_I |=> $stable(THRESHOLD_READOUT_O))
		else $error("threshold moved while level keys locked");
	chk_gnd_toggle: assert property (
		SETUP_MODE_O && KEY_GND_I && !KEY_MODE_I && KEY_CHAN_I == 4'h0
		|=> GND_O == ($past(GND_O) ^ $past(CHAN_SEL_O)))
		else $error("ground key did not toggle selected channel");
	chk_display_toggle: assert property (
		SETUP_MODE_O && KEY_DISPLAY_I && !KEY_MODE_I && KEY_CHAN_I == 4'h0
		|=> DISPLAY_EN_O == ($past(DISPLAY_EN_O) ^ $past(CHAN_SEL_O)))
		else $error("display key did not toggle selected channel");
	chk_prog_ignore: assert property (
		!SETUP_MODE_O && !KEY_MODE_I
		|=> $stable(GND_O) && $stable(DISPLAY_EN_O))
		else $error("channel setting changed in program mode");
endmodule

bind ltf_top ltf_props ltf_props_inst (.*);

`default_nettype wire

// *** test/ltf_top_tb.sv ***
// self-checking bench for the trigger and front-panel block
`default_nettype none
`include "ltf_regs.vh"

module ltf_top_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ********************
	// stimulus and checks
	// ********************
	logic REF_CLK_I, RESET_I, TRIG_RESET_I, QUALIFY_EN_I, SLOPE_RISE_I;
	logic REPLICA_SEL_I, GATE_VARIANT_I, KEY_MODE_I, KEY_DISPLAY_I;
	logic KEY_GND_I, KEY_IMP_I, KEY_FAMILY_I, KEY_SENS_UP_I, KEY_SENS_DN_I;
	logic KEY_READOUT_I, KEY_OFFSET_I, KEY_LVL_UP_I, KEY_LVL_DN_I, ext_run;
	logic [1:0] FUNC_SEL_I;
	logic [3:0] KEY_CHAN_I, lvl;
	logic [4:0] KEY_PROG_I;
	logic [7:0] FUNC_A_CARE_I, FUNC_A_POL_I, FUNC_B_CARE_I, FUNC_B_POL_I;
	logic [9:0] PROBE_VOLT_I;
	wire EXT_CLK_I, TRIG_O, REPLICA_O, SETUP_MODE_O, READOUT_ON_O;
	wire OFFSET_RED_O, OFFSET_GREEN_O;
	wire [3:0] CHAN_LEVEL_I, CHAN_SEL_O, DISPLAY_EN_O, GND_O, IMP_HIGH_O;
	wire [3:0] FAMILY_TTL_O;
	wire [7:0] SENS_O;
	wire [8:0] PROG_KEY_O;
	wire [9:0] SCALE_MV_O, READOUT_O;
	wire [39:0] THRESHOLD_READOUT_O;
	int errors = 0;
	int n_compared = 0;
	int cnt = 0;

	// short repeat counts keep held-key timing inside the run
	ltf_top #(.REP_SLOW_CYC(24'h000008), .REP_FAST_CYC(24'h000002),
		.PAUSE_CYC(24'h00000c)) ltf_top_inst (.*);
	ltf_cut ltf_cut_inst (.run_i(ext_run), .lvl_i(lvl),
		.ext_clk_o(EXT_CLK_I), .lvl_o(CHAN_LEVEL_I));

	initial begin
		REF_CLK_I = 1'b0;
		forever #20 REF_CLK_I = ~REF_CLK_I;
	end

	task chk(input logic [63:0] s, e, input string nm);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge REF_CLK_I);
		#1;
	endtask

	task run(input logic [3:0] lv, input int n);
		lvl = lv;
		repeat (n) begin
			tick(1);
			cnt += (TRIG_O === 1'b1);
		end
	endtask

	task press(input int k);
		case (k)
			0: KEY_FAMILY_I = 1'b1;
			1: KEY_READOUT_I = 1'b1;
			2: KEY_OFFSET_I = 1'b1;
			3: KEY_SENS_UP_I = 1'b1;
			4: KEY_MODE_I = 1'b1;
			5: KEY_GND_I = 1'b1;
			6: KEY_DISPLAY_I = 1'b1;
			7: KEY_CHAN_I = 4'h4;
			9: KEY_SENS_DN_I = 1'b1;
			10: KEY_IMP_I = 1'b1;
			default: KEY_CHAN_I = 4'h1;
		endcase
		tick(1);
		{KEY_FAMILY_I, KEY_READOUT_I, KEY_OFFSET_I, KEY_SENS_UP_I} = 4'h0;
		{KEY_MODE_I, KEY_GND_I, KEY_DISPLAY_I, KEY_CHAN_I} = 7'h00;
		{KEY_SENS_DN_I, KEY_IMP_I} = 2'h0;
		tick(2);
	endtask

	task close_out;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task t_reset;
		chk({SETUP_MODE_O, CHAN_SEL_O, GND_O, FAMILY_TTL_O}, 13'h110f, "st");
		chk(THRESHOLD_READOUT_O, {4{`LTF_TTL_PRESET}}, "threshold_readout");
		chk(SCALE_MV_O, `LTF_TTL_SC0, "scale");
	endtask

	task t_level;
		run(4'h1, 5);
		chk(TRIG_O, 1'b1, "level");
		TRIG_RESET_I = 1'b1;
		run(4'h1, 5);
		chk(TRIG_O, 1'b0, "inhibit");
		TRIG_RESET_I = 1'b0;
		press(6);
		run(4'h1, 3);
		chk(TRIG_O, 1'b1, "hidden");
		press(5);
		run(4'h1, 3);
		chk(TRIG_O, 1'b0, "grounded");
		press(5);
		press(6);
		FUNC_SEL_I = `LTF_SEL_B;
		run(4'h1, 5);
		chk(TRIG_O, 1'b0, "func b");
		run(4'h2, 5);
		chk(TRIG_O, 1'b1, "func b true");
	endtask

	task t_nest(input logic g);
		GATE_VARIANT_I = g;
		FUNC_SEL_I = `LTF_SEL_NEST;
		run(4'h0, 5);
		cnt = 0;
		run(4'h1, 5);
		run(4'h3, 10);
		run(4'h1, 6);
		run(4'h3, 6);
		run(4'h0, 5);
		chk(cnt, g ? 10 : 1, "fires");
		cnt = 0;
		run(4'h1, 5);
		TRIG_RESET_I = 1'b1;
		run(4'h0, 6);
		TRIG_RESET_I = 1'b0;
		run(4'h2, 8);
		chk(cnt, 0, "disarm");
	endtask

	task t_qual(input logic s);
		{GATE_VARIANT_I, FUNC_SEL_I, SLOPE_RISE_I} = {1'b0, `LTF_SEL_A, s};
		QUALIFY_EN_I = 1'b1;
		cnt = 0;
		ext_run = 1'b1;
		run(4'h0, 136);
		ext_run = 1'b0;
		chk(cnt, 8, "qualified");
		QUALIFY_EN_I = 1'b0;
		run(4'h0, 12);
	endtask

	task t_keys;
		press(2);
		chk(OFFSET_RED_O, 1'b0, "gated");
		press(7);
		chk(CHAN_SEL_O, 4'h4, "select");
		press(0);
		chk(THRESHOLD_READOUT_O[29:20], `LTF_ECL_PRESET, "ecl");
		chk(SCALE_MV_O, `LTF_ECL_SC0, "scale");
		repeat (3) press(3);
		chk({SENS_O[5:4], SCALE_MV_O}, {`LTF_SENS_MAX, `LTF_ECL_SC2}, "sens");
		press(9);
		chk({SENS_O[5:4], SCALE_MV_O}, {2'h1, `LTF_ECL_SC1}, "sens dn");
		press(10);
		chk(IMP_HIGH_O, 4'hb, "imp");
		press(1);
		chk(READOUT_O, `LTF_ECL_PRESET, "readout");
		KEY_LVL_UP_I = 1'b1;
		tick(1);
		KEY_LVL_UP_I = 1'b0;
		tick(2);
		chk(THRESHOLD_READOUT_O[29:20], `LTF_ECL_PRESET + 10'h001, "step");
		// held key: lands on preset, pauses 12, then waits 4, 2, 2
		KEY_LVL_DN_I = 1'b1;
		tick(1);
		chk(THRESHOLD_READOUT_O[29:20], `LTF_ECL_PRESET, "down");
		tick(12);
		chk(THRESHOLD_READOUT_O[29:20], `LTF_ECL_PRESET, "pause");
		tick(1);
		chk(THRESHOLD_READOUT_O[29:20], `LTF_ECL_PRESET - 10'h001, "rep1");
		tick(5);
		chk(THRESHOLD_READOUT_O[29:20], `LTF_ECL_PRESET - 10'h002, "rep2");
		tick(3);
		chk(THRESHOLD_READOUT_O[29:20], `LTF_ECL_PRESET - 10'h003, "rep3");
		KEY_LVL_DN_I = 1'b0;
		tick(2);
		press(0);
		chk(THRESHOLD_READOUT_O[29:20], `LTF_TTL_PRESET, "ttl");
		PROBE_VOLT_I = 10'h3f0;
		press(2);
		chk({OFFSET_RED_O, READOUT_O}, {1'b1, 10'h3f0}, "meter");
		press(2);
		chk({OFFSET_GREEN_O, THRESHOLD_READOUT_O[29:20]}, 11'h7f0, "capture");
		press(1);
		press(0);
		chk({READOUT_ON_O, READOUT_O, THRESHOLD_READOUT_O[29:20]}, 21'h0003f0, "kept");
		press(8);
		chk(OFFSET_GREEN_O, 1'b0, "other");
		press(7);
		chk(OFFSET_GREEN_O, 1'b1, "reminder");
		press(1);
		press(2);
		chk({OFFSET_GREEN_O, THRESHOLD_READOUT_O[29:20]}, {1'b0, `LTF_ECL_PRESET}, "clr");
		press(4);
		press(5);
		chk({SETUP_MODE_O, GND_O}, 5'h00, "prog");
		press(8);
		chk(CHAN_SEL_O, 4'h4, "chan prog");
		KEY_PROG_I = 5'h10;
		tick(1);
		chk(PROG_KEY_O, 9'h010, "prog key");
		KEY_PROG_I = 5'h00;
		tick(1);
		chk(PROG_KEY_O, 9'h000, "prog key end");
		press(4);
		KEY_PROG_I = 5'h10;
		tick(1);
		chk(PROG_KEY_O, 9'h000, "prog key setup");
		KEY_PROG_I = 5'h00;
		tick(1);
	endtask

	initial begin
		{TRIG_RESET_I, QUALIFY_EN_I, SLOPE_RISE_I, GATE_VARIANT_I} = 4'h0;
		{KEY_MODE_I, KEY_DISPLAY_I, KEY_GND_I, KEY_IMP_I} = 4'h0;
		{KEY_FAMILY_I, KEY_SENS_UP_I, KEY_SENS_DN_I, KEY_READOUT_I} = 4'h0;
		{KEY_OFFSET_I, KEY_LVL_UP_I, KEY_LVL_DN_I, ext_run} = 4'h0;
		{KEY_CHAN_I, lvl, KEY_PROG_I, PROBE_VOLT_I} = 23'h000000;
		{REPLICA_SEL_I, FUNC_SEL_I} = {1'b1, `LTF_SEL_A};
		{FUNC_A_CARE_I, FUNC_A_POL_I} = 16'h0101;
		{FUNC_B_CARE_I, FUNC_B_POL_I} = 16'h0202;
		RESET_I = 1'b1;
		tick(16);
		RESET_I = 1'b0;
		tick(1);
		t_reset();
		t_level();
		t_nest(1'b0);
		t_nest(1'b1);
		t_qual(1'b1);
		t_qual(1'b0);
		t_keys();
		close_out();
	end

	// about four times the expected run length
	initial begin
		#100000;
		errors++;
		close_out();
	end
endmodule

`default_nettype wire
